/* slpm_pkg.sv */
package slpm_pkg;
	// ==========================================
	// register offsets
	localparam logic [7:0] SLPM_OFF_UP_SPLIT = 8'h88;
	localparam logic [7:0] SLPM_OFF_DN_SPLIT = 8'h8c;
	localparam logic [7:0] SLPM_OFF_PM_CAP = 8'h90;
	localparam logic [7:0] SLPM_OFF_PRI_STAT = 8'h84;
	// ==========================================
	// field positions
	localparam int SLPM_LIMIT_LSB = 16;
	localparam int SLPM_DELAYED_BIT = 21;
	// ==========================================
	// reset and constant values
	localparam logic [15:0] SLPM_LIMIT_RST = 16'h0020;
	localparam logic [15:0] SLPM_CAPACITY = 16'h0020;
	localparam logic [15:0] SLPM_LIMIT_ALL = 16'hffff;
	localparam logic [15:0] SLPM_LIMIT_FREE = 16'h0100;
	localparam logic [7:0] SLPM_PM_ID = 8'h01;
	localparam logic [7:0] SLPM_NEXT_PTR = 8'h00;
	localparam logic [4:0] SLPM_WAKE_PIN = 5'h00;
	localparam logic [1:0] SLPM_D2_D1 = 2'h0;
	localparam logic [2:0] SLPM_AUX_CUR = 3'h0;
	localparam logic [0:0] SLPM_DSI = 1'h0;
	localparam logic [1:0] SLPM_RSV_CLK = 2'h0;
	localparam logic [2:0] SLPM_VERSION = 3'h2;
	// ==========================================
	// forwarding request widths
	localparam int SLPM_SIZE_W = 16;
endpackage

/* slpm_dir_if.sv */
`timescale 1ns/1ps
interface slpm_dir_if;
	import slpm_pkg::*;
	logic [15:0] limit;
	logic [SLPM_SIZE_W-1:0] outstanding;
	logic [SLPM_SIZE_W-1:0] req_size;
	logic req_valid;
	logic allow;
	logic held;
	modport gate (input limit, input outstanding, input req_size,
		input req_valid, output allow, output held);
	modport user (output limit, output outstanding, output req_size,
		output req_valid, input allow, input held);
endinterface

/* slpm_split_gate.sv */
`timescale 1ns/1ps
module slpm_split_gate
	import slpm_pkg::*;
(
	slpm_dir_if.gate d
);
	// ==========================================
	// forward decision
	wire [16:0] need;
	wire unlimited;
	wire fits;
	assign need = {1'b0, d.outstanding} + {1'b0, d.req_size};
	// large limits bypass the space check entirely
	assign unlimited = (d.limit == SLPM_LIMIT_ALL) ||
		(d.limit >= SLPM_LIMIT_FREE);
	assign fits = need <= {1'b0, d.limit};
	assign d.allow = d.req_valid && (unlimited || fits);
	assign d.held = d.req_valid && !(unlimited || fits);
endmodule

/* slpm_regs.sv */
`timescale 1ns/1ps
module slpm_regs
	import slpm_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic [3:0] cfg_be,
	output logic [31:0] cfg_rdata,
	input wire logic up_req_valid,
	input wire logic [SLPM_SIZE_W-1:0] up_req_size,
	input wire logic [SLPM_SIZE_W-1:0] up_outstanding,
	output logic up_allow,
	input wire logic dn_req_valid,
	input wire logic [SLPM_SIZE_W-1:0] dn_req_size,
	input wire logic [SLPM_SIZE_W-1:0] dn_outstanding,
	output logic dn_allow,
	output logic split_delayed
);
	import slpm_pkg::*;
	default clocking dclk @(posedge mclk); endclocking
	default disable iff (!rstn);

	// ==========================================
	// address decode
	wire hit_up;
	wire hit_dn;
	wire hit_pm;
	wire hit_st;
	assign hit_up = cfg_addr == SLPM_OFF_UP_SPLIT;
	assign hit_dn = cfg_addr == SLPM_OFF_DN_SPLIT;
	assign hit_pm = cfg_addr == SLPM_OFF_PM_CAP;
	assign hit_st = cfg_addr == SLPM_OFF_PRI_STAT;

	// ==========================================
	// limit registers
	logic [15:0] up_limit_r;
	logic [15:0] up_limit_nxt;
	logic [15:0] dn_limit_r;
	logic [15:0] dn_limit_nxt;
	wire [15:0] wr_hi;
	assign wr_hi = cfg_wdata[31:16];

	// byte lanes 3:2 carry the limit; lanes 1:0 hit constants only
	assign up_limit_nxt = {
		(cfg_wr && hit_up && cfg_be[3]) ? wr_hi[15:8] : up_limit_r[15:8],
		(cfg_wr && hit_up && cfg_be[2]) ? wr_hi[7:0] : up_limit_r[7:0]};
	assign dn_limit_nxt = {
		(cfg_wr && hit_dn && cfg_be[3]) ? wr_hi[15:8] : dn_limit_r[15:8],
		(cfg_wr && hit_dn && cfg_be[2]) ? wr_hi[7:0] : dn_limit_r[7:0]};

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			up_limit_r <= SLPM_LIMIT_RST;
			dn_limit_r <= SLPM_LIMIT_RST;
		end else begin
			up_limit_r <= up_limit_nxt;
			dn_limit_r <= dn_limit_nxt;
		end
	end

	// ==========================================
	// forwarding gates
	slpm_dir_if up_if ();
	slpm_dir_if dn_if ();
	assign up_if.limit = up_limit_r;
	assign up_if.outstanding = up_outstanding;
	assign up_if.req_size = up_req_size;
	assign up_if.req_valid = up_req_valid;
	assign dn_if.limit = dn_limit_r;
	assign dn_if.outstanding = dn_outstanding;
	assign dn_if.req_size = dn_req_size;
	assign dn_if.req_valid = dn_req_valid;

	slpm_split_gate u_up_gate (
		.d (up_if.gate)
	);
	slpm_split_gate u_dn_gate (
		.d (dn_if.gate)
	);
	assign up_allow = up_if.allow;
	assign dn_allow = dn_if.allow;

	// ==========================================
	// delayed flag, write one to clear; a new hold wins over the clear
	logic delayed_r;
	logic delayed_nxt;
	wire st_clr;
	assign st_clr = cfg_wr && hit_st && cfg_be[2] &&
		cfg_wdata[SLPM_DELAYED_BIT];
	assign delayed_nxt = up_if.held ? 1'b1 :
		(st_clr ? 1'b0 : delayed_r);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			delayed_r <= 1'b0;
		end else begin
			delayed_r <= delayed_nxt;
		end
	end
	assign split_delayed = delayed_r;

	// ==========================================
	// read data
	wire [31:0] pm_word;
	wire [31:0] rd_mux;
	assign pm_word = {SLPM_WAKE_PIN, SLPM_D2_D1, SLPM_AUX_CUR, SLPM_DSI,
		SLPM_RSV_CLK, SLPM_VERSION, SLPM_NEXT_PTR, SLPM_PM_ID};
	// capacity half is constant
	assign rd_mux = hit_up ? {up_limit_r, SLPM_CAPACITY} :
		hit_dn ? {dn_limit_r, SLPM_CAPACITY} :
		hit_pm ? pm_word :
		hit_st ? ({31'h0000_0000, delayed_r} << SLPM_DELAYED_BIT) :
		32'h0000_0000;

	// unmapped offsets read zero
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfg_rdata <= 32'h0000_0000;
		end else if (cfg_rd) begin
			cfg_rdata <= rd_mux;
		end
	end

	// ==========================================
	// checks
	// limit reset values, readback and in-limit forwarding
	a_limit_reset: assert property (
		$rose(rstn) |-> up_limit_r == 16'h0020)
		else $error("upstream limit not at reset value");

	a_dn_limit_reset: assert property (
		$rose(rstn) |-> dn_limit_r == 16'h0020)
		else $error("downstream limit not at reset value");

	a_up_limit_read: assert property (
		cfg_rd && hit_up |=> cfg_rdata[31:16] == $past(up_limit_r))
		else $error("upstream limit readback wrong");

	a_dn_limit_read: assert property (
		cfg_rd && hit_dn |=> cfg_rdata[31:16] == $past(dn_limit_r))
		else $error("downstream limit readback wrong");

	a_up_fit_fwd: assert property (
		up_req_valid && ({1'b0, up_outstanding} + {1'b0, up_req_size} <=
		{1'b0, up_limit_r}) |-> up_allow)
		else $error("upstream request within limit refused");

	a_dn_fit_fwd: assert property (
		dn_req_valid && ({1'b0, dn_outstanding} + {1'b0, dn_req_size} <=
		{1'b0, dn_limit_r}) |-> dn_allow)
		else $error("downstream request within limit refused");

	// capacity halves are constant
	a_cap_read: assert property (
		cfg_rd && hit_up |=> cfg_rdata[15:0] == 16'h0020)
		else $error("upstream capacity half wrong");

	a_dn_cap_read: assert property (
		cfg_rd && hit_dn |=> cfg_rdata[15:0] == 16'h0020)
		else $error("downstream capacity half wrong");

	// forwarding decisions, free and limited
	a_free_fwd: assert property (
		up_req_valid && up_limit_r >= 16'h0100 |-> up_allow)
		else $error("upstream not forwarded");

	a_dn_free: assert property (
		dn_req_valid && dn_limit_r >= 16'h0100 |-> dn_allow)
		else $error("downstream not forwarded");

	a_all_fwd: assert property (
		dn_req_valid && dn_limit_r == 16'hffff |-> dn_allow)
		else $error("downstream ffff limit refused");

	a_up_all_fwd: assert property (
		up_req_valid && up_limit_r == 16'hffff |-> up_allow)
		else $error("upstream ffff limit refused");

	a_up_over_held: assert property (
		up_req_valid && up_limit_r < 16'h0100 &&
		({1'b0, up_outstanding} + {1'b0, up_req_size} >
		{1'b0, up_limit_r}) |-> !up_allow)
		else $error("upstream request over limit forwarded");

	a_dn_over_held: assert property (
		dn_req_valid && dn_limit_r < 16'h0100 &&
		({1'b0, dn_outstanding} + {1'b0, dn_req_size} >
		{1'b0, dn_limit_r}) |-> !dn_allow)
		else $error("downstream request over limit forwarded");

	a_up_idle: assert property (
		!up_req_valid |-> !up_allow)
		else $error("upstream allow without request");

	a_dn_idle: assert property (
		!dn_req_valid |-> !dn_allow)
		else $error("downstream allow without request");

	// limit writes per byte lane
	a_limit_write: assert property (
		cfg_wr && hit_dn && cfg_be[3:2] == 2'h3 |=>
		dn_limit_r == $past(cfg_wdata[31:16]))
		else $error("downstream limit write lost");

	a_up_write: assert property (
		cfg_wr && hit_up && cfg_be[3:2] == 2'h3 |=>
		up_limit_r == $past(cfg_wdata[31:16]))
		else $error("upstream limit write lost");

	a_up_lane_hi: assert property (
		cfg_wr && hit_up && cfg_be[3:2] == 2'h2 |=>
		up_limit_r == {$past(cfg_wdata[31:24]), $past(up_limit_r[7:0])})
		else $error("upstream high lane write wrong");

	a_up_lane_lo: assert property (
		cfg_wr && hit_up && cfg_be[3:2] == 2'h1 |=>
		up_limit_r == {$past(up_limit_r[15:8]), $past(cfg_wdata[23:16])})
		else $error("upstream low lane write wrong");

	a_dn_lane_hi: assert property (
		cfg_wr && hit_dn && cfg_be[3:2] == 2'h2 |=>
		dn_limit_r == {$past(cfg_wdata[31:24]), $past(dn_limit_r[7:0])})
		else $error("downstream high lane write wrong");

	a_dn_lane_lo: assert property (
		cfg_wr && hit_dn && cfg_be[3:2] == 2'h1 |=>
		dn_limit_r == {$past(dn_limit_r[15:8]), $past(cfg_wdata[23:16])})
		else $error("downstream low lane write wrong");

	// power management capability fields, each on its own
	a_pm_read: assert property (
		cfg_rd && hit_pm |=> cfg_rdata == 32'h0002_0001)
		else $error("pm capability word wrong");

	a_pm_id: assert property (
		cfg_rd && hit_pm |=> cfg_rdata[7:0] == 8'h01)
		else $error("pm id byte wrong");

	a_next_ptr: assert property (
		cfg_rd && hit_pm |=> cfg_rdata[15:8] == 8'h00)
		else $error("next pointer byte wrong");

	a_wake_pin: assert property (
		cfg_rd && hit_pm |=> cfg_rdata[31:27] == 5'h00)
		else $error("wake pin field wrong");

	a_d2_d1: assert property (
		cfg_rd && hit_pm |=> cfg_rdata[26:25] == 2'h0)
		else $error("d2 d1 support bits wrong");

	a_aux_cur: assert property (
		cfg_rd && hit_pm |=> cfg_rdata[24:22] == 3'h0)
		else $error("aux current field wrong");

	a_dsi_bit: assert property (
		cfg_rd && hit_pm |=> cfg_rdata[21] == 1'b0)
		else $error("device init bit wrong");

	a_pme_clk: assert property (
		cfg_rd && hit_pm |=> cfg_rdata[20:19] == 2'h0)
		else $error("wake clock or reserved bit wrong");

	a_version: assert property (
		cfg_rd && hit_pm |=> cfg_rdata[18:16] == 3'h2)
		else $error("version field wrong");

	// sticky delayed flag; a hold in the clear cycle must win
	a_delay_set: assert property (
		up_req_valid && !up_allow |=> split_delayed)
		else $error("delayed flag not set");

	a_delay_hold: assert property (
		split_delayed && !st_clr |=> split_delayed)
		else $error("delayed flag lost without clear");

	a_delay_clear: assert property (
		st_clr && !(up_req_valid && !up_allow) |=> !split_delayed)
		else $error("delayed flag not cleared");

	a_delay_win: assert property (
		st_clr && up_req_valid && !up_allow |=> split_delayed)
		else $error("clear won over a new hold");

	a_dn_no_delay: assert property (
		!split_delayed && !(up_req_valid && !up_allow) |=> !split_delayed)
		else $error("delayed flag set without upstream hold");

	a_status_read: assert property (
		cfg_rd && hit_st |=>
		cfg_rdata == {10'h000, $past(split_delayed), 21'h00_0000})
		else $error("status word wrong");

	// read-only fields and read data
	a_ro_stable: assert property (
		cfg_wr && hit_up && cfg_be[3:2] == 2'h0 |=> $stable(up_limit_r))
		else $error("upstream read-only write changed state");

	a_dn_ro_stable: assert property (
		cfg_wr && hit_dn && cfg_be[3:2] == 2'h0 |=> $stable(dn_limit_r))
		else $error("downstream read-only write changed state");

	a_pm_wr_ignored: assert property (
		cfg_wr && hit_pm |=> $stable(up_limit_r) && $stable(dn_limit_r))
		else $error("pm write changed a limit");

	a_rdata_hold: assert property (
		!cfg_rd |=> $stable(cfg_rdata))
		else $error("read data changed without a read");

	a_unmapped_read: assert property (
		cfg_rd && !hit_up && !hit_dn && !hit_pm && !hit_st |=>
		cfg_rdata == 32'h0000_0000)
		else $error("unmapped offset read not zero");
endmodule

/* slpm_regs_test.sv */
`timescale 1ns/1ps
module slpm_regs_test;
	import slpm_pkg::*;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [31:0] cfg_wdata = 32'h0000_0000;
	logic [3:0] cfg_be = 4'h0;
	logic [31:0] cfg_rdata;
	logic up_req_valid = 1'b0;
	logic [15:0] up_req_size = 16'h0000;
	logic [15:0] up_outstanding = 16'h0000;
	logic up_allow;
	logic dn_req_valid = 1'b0;
	logic [15:0] dn_req_size = 16'h0000;
	logic [15:0] dn_outstanding = 16'h0000;
	logic dn_allow;
	logic split_delayed;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	// sums above each limit on purpose, so only the free-forward path allows
	logic [15:0] lims [3] = '{16'h00ff, 16'h0100, 16'hffff};
	logic [15:0] outs [3] = '{16'h00f0, 16'h00f0, 16'hf000};
	logic [15:0] szs [3] = '{16'h0020, 16'h0020, 16'h2000};
	logic exps [3] = '{1'b0, 1'b1, 1'b1};

	slpm_regs uut (.mclk(mclk), .rstn(rstn), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_be(cfg_be), .cfg_rdata(cfg_rdata),
		.up_req_valid(up_req_valid), .up_req_size(up_req_size),
		.up_outstanding(up_outstanding), .up_allow(up_allow),
		.dn_req_valid(dn_req_valid), .dn_req_size(dn_req_size),
		.dn_outstanding(dn_outstanding), .dn_allow(dn_allow),
		.split_delayed(split_delayed));

	always #2 mclk = ~mclk;

	// ==========================================
	// checking and access tasks
	task automatic final_report();
		if (errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk32(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(negedge mclk);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_be = be;
		@(negedge mclk);
		cfg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(negedge mclk);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge mclk);
		cfg_rd = 1'b0;
		chk32("cfg_rdata", exp, cfg_rdata);
	endtask

	// one request held across a single edge; limit written first
	task automatic fwd(input logic up, input logic [15:0] lim,
		input logic [15:0] outst, input logic [15:0] sz, input logic exp);
		wr(up ? SLPM_OFF_UP_SPLIT : SLPM_OFF_DN_SPLIT, {lim, 16'h0000}, 4'hc);
		@(negedge mclk);
		{up_req_valid, up_outstanding, up_req_size} = {up, outst, sz};
		{dn_req_valid, dn_outstanding, dn_req_size} = {~up, outst, sz};
		#1;
		chk1("allow", exp, up ? up_allow : dn_allow);
		@(negedge mclk);
		up_req_valid = 1'b0;
		dn_req_valid = 1'b0;
	endtask

	// ==========================================
	// watchdog
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			final_report();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (4) @(negedge mclk);
		rstn = 1'b1;
		rd(8'h88, 32'h0020_0020);
		rd(8'h8c, 32'h0020_0020);
		rd(8'h90, 32'h0002_0001);
		rd(8'h84, 32'h0000_0000);
		rd(8'h00, 32'h0000_0000);
		wr(8'h90, 32'hffff_ffff, 4'hf);
		rd(8'h90, 32'h0002_0001);
		wr(8'h88, 32'hffff_ffff, 4'hf);
		rd(8'h88, 32'hffff_0020);
		wr(8'h8c, 32'h1234_5678, 4'h8);
		rd(8'h8c, 32'h1220_0020);
		for (int i = 0; i < 3; i++) begin
			fwd(1'b0, lims[i], outs[i], szs[i], exps[i]);
		end
		chk1("split_delayed", 1'b0, split_delayed);
		fwd(1'b1, 16'h0020, 16'h0010, 16'h0010, 1'b1);
		for (int i = 0; i < 3; i++) begin
			fwd(1'b1, lims[i], outs[i], szs[i], exps[i]);
		end
		chk1("split_delayed", 1'b1, split_delayed);
		rd(8'h84, 32'h0020_0000);
		wr(8'h84, 32'h0020_0000, 4'h4);
		rd(8'h84, 32'h0000_0000);
		final_report();
	end
endmodule
